//--- hdl/adcsfc_top.v
// sample trigger, end-of-conversion / interrupt pin and frame start control
// assumes pins arrive asynchronously; the converter core sits on clk_sys_i
//
// What this block does
// - in extended sampling mode a falling trigger starts sampling.
// - a rising trigger puts the sample/hold into hold and starts a conversion in the same cycle.
// - the sampling period lasts exactly as long as the trigger stays low.
// - the trigger acts regardless of sclk, chip select and frame sync.
// - the status pin is an end-of-conversion flag in mode 00, else an interrupt.
// - as a flag it goes low at end of sampling and stays low until data is ready.
// - as an interrupt it falls to signal that conversion data is ready.
// - a pending interrupt clears on cs fall, frame sync rise or trigger fall.
// - a rising frame sync marks the start of a serial frame either way.
// - with frame sync low at cs fall, the next frame sync rise starts the cycle.
// - cs fall clears the counter, enables sdi, sclk and sdo; with fs high it starts.
`timescale 1ns/10ps
`default_nettype none
`include "adcsfc_defines.vh"

module adcsfc_top (
    input wire clk_sys_i,
    input wire rst_i,
    input wire ext_sample_trigger_n_i,
    input wire frame_sync_in_i,
    input wire chip_select_n_i,
    input wire serial_clk_i,
    input wire ext_sampling_mode_i,
    input wire [1:0] conv_mode_i,
    input wire sample_end_i,
    input wire conv_done_i,
    output reg sampling_o,
    output reg conv_start_o,
    output reg conv_busy_o,
    output reg status_n_o,
    output reg frame_start_o,
    output reg cycle_active_o,
    output reg serial_en_o,
    output reg sdo_oe_o,
    output reg [3:0] edge_count_o,
    output reg early_trigger_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire [`ADCSFC_NPIN-1:0] pins_raw;
    wire [`ADCSFC_NPIN-1:0] pin_level;
    wire [`ADCSFC_NPIN-1:0] pin_rise;
    wire [`ADCSFC_NPIN-1:0] pin_fall;
    localparam [`ADCSFC_NPIN-1:0] PIN_RST = `ADCSFC_PIN_RST;

    assign pins_raw[`ADCSFC_PIN_TRIG] = ext_sample_trigger_n_i;
    assign pins_raw[`ADCSFC_PIN_FS] = frame_sync_in_i;
    assign pins_raw[`ADCSFC_PIN_CS] = chip_select_n_i;
    assign pins_raw[`ADCSFC_PIN_SCLK] = serial_clk_i;

    // every host pin is resynchronised; edges come from the filtered level
    genvar gi;
    generate
        for (gi = 0; gi < `ADCSFC_NPIN; gi = gi + 1) begin : g_sync
            adcsfc_sync #(
                .RST_LEVEL(PIN_RST[gi])
            ) u_sync (
                .clk_sys_i(clk_sys_i),
                .rst_i(rst_i),
                .pin_i(pins_raw[gi]),
                .level_o(pin_level[gi]),
                .rise_o(pin_rise[gi]),
                .fall_o(pin_fall[gi])
            );
        end
    endgenerate

    wire trig_fall = pin_fall[`ADCSFC_PIN_TRIG];
    wire trig_rise = pin_rise[`ADCSFC_PIN_TRIG];
    wire fs_level = pin_level[`ADCSFC_PIN_FS];
    wire fs_rise = pin_rise[`ADCSFC_PIN_FS];
    wire cs_n_level = pin_level[`ADCSFC_PIN_CS];
    wire cs_fall = pin_fall[`ADCSFC_PIN_CS];
    wire cs_rise = pin_rise[`ADCSFC_PIN_CS];
    wire sclk_rise = pin_rise[`ADCSFC_PIN_SCLK];
    wire sclk_fall = pin_fall[`ADCSFC_PIN_SCLK];

    // ------------------------------------------------------------
    // sampling and conversion start
    // ------------------------------------------------------------
    // trigger edges are used in extended mode with no gate from sclk, cs or
    // fs; a trigger that idles high therefore never opens a sample window
    wire ext_start = ext_sampling_mode_i & trig_fall;
    wire ext_stop = ext_sampling_mode_i & trig_rise & sampling_o;
    wire sample_done = ext_stop | (~ext_sampling_mode_i & sample_end_i);

    // the sample window spans exactly the low time of the trigger
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            sampling_o <= 1'b0;
        end else if (ext_start) begin
            sampling_o <= 1'b1;
        end else if (ext_stop) begin
            sampling_o <= 1'b0;
        end
    end

    // hold is taken in the same edge that registers the start pulse
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            conv_start_o <= 1'b0;
        end else begin
            conv_start_o <= ext_stop;
        end
    end

    // busy relies on the host keeping the trigger high until done;
    // a done in the start cycle is ignored, start wins
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            conv_busy_o <= 1'b0;
        end else if (conv_start_o) begin
            conv_busy_o <= 1'b1;
        end else if (conv_done_i) begin
            conv_busy_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // early trigger watch
    // ------------------------------------------------------------
    reg [3:0] sclk_rises_q;
    reg [3:0] sclk_rises_d;
    reg first_trig_seen_q;

    // saturating count of sclk rises seen since reset
    always @* begin
        sclk_rises_d = sclk_rises_q;
        if (sclk_rise && sclk_rises_q != `ADCSFC_SCLK_FIRST_TRIG) begin
            sclk_rises_d = sclk_rises_q + 4'h1;
        end
    end

    // flags a first trigger fall that came before the 11th sclk rise;
    // the trigger is still obeyed, the flag only reports the violation
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            sclk_rises_q <= 4'h0;
            first_trig_seen_q <= 1'b0;
            early_trigger_o <= 1'b0;
        end else begin
            sclk_rises_q <= sclk_rises_d;
            if (trig_fall && !first_trig_seen_q) begin
                first_trig_seen_q <= 1'b1;
                if (sclk_rises_q != `ADCSFC_SCLK_FIRST_TRIG) begin
                    early_trigger_o <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // end-of-conversion / interrupt pin
    // ------------------------------------------------------------
    wire eoc_use = (conv_mode_i == `ADCSFC_MODE_EOC);
    wire int_clear = cs_fall | fs_rise | trig_fall;

    // flag mode: low from end of sampling until data ready;
    // interrupt mode: fall on data ready, rise on the next clear event;
    // a data-ready in the clear cycle wins so the event is not lost
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            status_n_o <= 1'b1;
        end else if (eoc_use) begin
            if (sample_done) begin
                status_n_o <= 1'b0;
            end else if (conv_done_i) begin
                status_n_o <= 1'b1;
            end
        end else begin
            if (conv_done_i) begin
                status_n_o <= 1'b0;
            end else if (int_clear) begin
                status_n_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // frame start and edge counter
    // ------------------------------------------------------------
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg start_d;
    reg clear_d;
    reg en_d;
    reg oe_d;

    // fs rise with cs low starts a frame from any state, so a chip select
    // tied low still works; a host with fs tied high starts on cs fall
    always @* begin
        state_d = state_q;
        start_d = 1'b0;
        clear_d = 1'b0;
        en_d = serial_en_o;
        oe_d = sdo_oe_o;
        case (state_q)
            `ADCSFC_ST_IDLE: begin
                if (cs_fall) begin
                    clear_d = 1'b1;
                    en_d = 1'b1;
                    oe_d = 1'b1;
                    if (fs_level) begin
                        state_d = `ADCSFC_ST_ACTIVE;
                        start_d = 1'b1;
                    end else begin
                        state_d = `ADCSFC_ST_ARMED;
                    end
                end else if (fs_rise && !cs_n_level) begin
                    state_d = `ADCSFC_ST_ACTIVE;
                    start_d = 1'b1;
                    clear_d = 1'b1;
                    en_d = 1'b1;
                    oe_d = 1'b1;
                end
            end
            `ADCSFC_ST_ARMED: begin
                if (fs_rise) begin
                    state_d = `ADCSFC_ST_ACTIVE;
                    start_d = 1'b1;
                    clear_d = 1'b1;
                    en_d = 1'b1;
                    oe_d = 1'b1;
                end
            end
            `ADCSFC_ST_ACTIVE: begin
                if (fs_rise) begin
                    start_d = 1'b1;
                    clear_d = 1'b1;
                    en_d = 1'b1;
                    oe_d = 1'b1;
                end else if (sclk_fall && edge_count_o == `ADCSFC_EDGE_LAST) begin
                    state_d = `ADCSFC_ST_DONE;
                    en_d = 1'b0;
                    oe_d = 1'b0;
                end
            end
            `ADCSFC_ST_DONE: begin
                if (fs_rise) begin
                    state_d = `ADCSFC_ST_ACTIVE;
                    start_d = 1'b1;
                    clear_d = 1'b1;
                    en_d = 1'b1;
                    oe_d = 1'b1;
                end
            end
            default: begin
                state_d = `ADCSFC_ST_IDLE;
                en_d = 1'b0;
                oe_d = 1'b0;
            end
        endcase
        // cs high ends everything; it outranks any edge in the same cycle
        if (cs_rise) begin
            state_d = `ADCSFC_ST_IDLE;
            start_d = 1'b0;
            clear_d = 1'b0;
            en_d = 1'b0;
            oe_d = 1'b0;
        end
    end

    // state, enables and the one-cycle frame start pulse
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_q <= `ADCSFC_ST_IDLE;
            frame_start_o <= 1'b0;
            cycle_active_o <= 1'b0;
            serial_en_o <= 1'b0;
            sdo_oe_o <= 1'b0;
        end else begin
            state_q <= state_d;
            frame_start_o <= start_d;
            cycle_active_o <= (state_d == `ADCSFC_ST_ACTIVE);
            serial_en_o <= en_d;
            sdo_oe_o <= oe_d;
        end
    end

    // edge counter counts sclk falls only inside an active cycle
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            edge_count_o <= 4'h0;
        end else if (clear_d) begin
            edge_count_o <= 4'h0;
        end else if (state_q == `ADCSFC_ST_ACTIVE && sclk_fall) begin
            edge_count_o <= edge_count_o + 4'h1;
        end
    end

endmodule
`default_nettype wire

//--- hdl/adcsfc_defines.vh
// constants for the sample trigger, status pin and frame start control
// assumes it is included by bare name from every design file of the block
`ifndef ADCSFC_DEFINES_VH
`define ADCSFC_DEFINES_VH

// ----------------------------------------------------------------
// synchronised pin vector layout
// ----------------------------------------------------------------
`define ADCSFC_NPIN 4
`define ADCSFC_PIN_TRIG 0
`define ADCSFC_PIN_FS 1
`define ADCSFC_PIN_CS 2
`define ADCSFC_PIN_SCLK 3
// idle levels of the pins: trigger high, frame sync high, cs high, sclk low
`define ADCSFC_PIN_RST 4'h7

// ----------------------------------------------------------------
// modes and counts
// ----------------------------------------------------------------
`define ADCSFC_MODE_EOC 2'h0
`define ADCSFC_EDGE_LAST 4'hf
`define ADCSFC_SCLK_FIRST_TRIG 4'hb

// ----------------------------------------------------------------
// frame control states
// ----------------------------------------------------------------
`define ADCSFC_ST_IDLE 2'h0
`define ADCSFC_ST_ARMED 2'h1
`define ADCSFC_ST_ACTIVE 2'h2
`define ADCSFC_ST_DONE 2'h3

`endif

//--- hdl/adcsfc_sync.v
// three-stage synchroniser with agreement filter and edge pulses
// assumes the input is asynchronous to clk_sys_i; reset is synchronous
`timescale 1ns/10ps
`default_nettype none
`include "adcsfc_defines.vh"

module adcsfc_sync #(
    parameter [0:0] RST_LEVEL = 1'b1
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire pin_i,
    output reg level_o,
    output reg rise_o,
    output reg fall_o
);

    // ------------------------------------------------------------
    // flop chain
    // ------------------------------------------------------------
    reg meta_q;
    reg stage2_q;
    reg stage3_q;

    // meta_q is read only by stage2_q so a metastable value never fans out
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            meta_q <= RST_LEVEL;
            stage2_q <= RST_LEVEL;
            stage3_q <= RST_LEVEL;
        end else begin
            meta_q <= pin_i;
            stage2_q <= meta_q;
            stage3_q <= stage2_q;
        end
    end

    // ------------------------------------------------------------
    // filtered level and edges
    // ------------------------------------------------------------
    // a change is accepted only once stages two and three agree
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            level_o <= RST_LEVEL;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            rise_o <= 1'b0;
            fall_o <= 1'b0;
            if (stage2_q == stage3_q && stage3_q != level_o) begin
                level_o <= stage3_q;
                rise_o <= stage3_q;
                fall_o <= ~stage3_q;
            end
        end
    end

endmodule
`default_nettype wire

//--- testbench/adcsfc_top_sva.sv
// assertions on the trigger, status and frame ports of adcsfc_top
// assumes one clk_sys_i domain with synchronous active-high rst_i
`timescale 1ns/10ps
`default_nettype none

module adcsfc_top_sva (
    input wire clk_sys_i,
    input wire rst_i,
    input wire ext_sample_trigger_n_i,
    input wire frame_sync_in_i,
    input wire chip_select_n_i,
    input wire serial_clk_i,
    input wire ext_sampling_mode_i,
    input wire [1:0] conv_mode_i,
    input wire sample_end_i,
    input wire conv_done_i,
    input wire sampling_o,
    input wire conv_start_o,
    input wire conv_busy_o,
    input wire status_n_o,
    input wire frame_start_o,
    input wire cycle_active_o,
    input wire serial_en_o,
    input wire sdo_oe_o,
    input wire [3:0] edge_count_o,
    input wire early_trigger_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------
    // multi-step behaviours
    // ------------------------------------------------------------
    sequence s_hold_start;
        conv_start_o ##1 (!conv_start_o && conv_busy_o);
    endsequence
    sequence s_frame_open;
        frame_start_o && serial_en_o && sdo_oe_o && edge_count_o == 4'h0;
    endsequence

    // pin windows are wide enough that the synchroniser delay never hides
    // the start pulse is registered in the same edge that closes the window
    a_close_starts: assert property (
        $fell(sampling_o) |-> s_hold_start)
        else $error("no single start pulse after window close");
    a_early_sticky: assert property (
        early_trigger_o |=> early_trigger_o)
        else $error("early trigger flag dropped without reset");
    a_busy_ends: assert property (
        conv_busy_o && conv_done_i |=> !conv_busy_o)
        else $error("busy outlived conversion done");
    a_window_pin: assert property (
        $changed(sampling_o) |-> sampling_o != ext_sample_trigger_n_i)
        else $error("sample window does not follow trigger level");
    a_ext_only: assert property (
        $rose(sampling_o) |-> ext_sampling_mode_i)
        else $error("window opened outside extended mode");
    a_eoc_low: assert property (
        conv_mode_i == 2'h0 && $fell(sampling_o) |-> !status_n_o)
        else $error("flag not low at end of sampling");
    a_eoc_done: assert property (
        conv_mode_i == 2'h0 && conv_done_i && !sample_end_i && !sampling_o
        |=> status_n_o)
        else $error("flag not released on conversion done");
    a_int_done: assert property (
        conv_mode_i != 2'h0 && conv_done_i |=> !status_n_o)
        else $error("interrupt not raised on data ready");
    a_int_clear: assert property (
        conv_mode_i != 2'h0 && $fell(chip_select_n_i) |-> ##[3:6] status_n_o)
        else $error("interrupt not cleared by chip select fall");
    a_frame_open: assert property (
        $rose(cycle_active_o) |-> s_frame_open)
        else $error("cycle opened without counter clear and enables");
    a_fs_restart: assert property (
        $rose(frame_sync_in_i) && !chip_select_n_i |-> ##[3:6] frame_start_o)
        else $error("frame sync rise did not start a frame");
    a_cs_enable: assert property (
        $fell(chip_select_n_i) |-> ##[3:6] serial_en_o && sdo_oe_o)
        else $error("chip select fall did not enable serial port");
    a_cs_release: assert property (
        $rose(chip_select_n_i) |-> ##[3:6] !serial_en_o && !sdo_oe_o)
        else $error("chip select rise left serial port enabled");
endmodule

bind adcsfc_top adcsfc_top_sva u_sva (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ext_sample_trigger_n_i(ext_sample_trigger_n_i),
    .frame_sync_in_i(frame_sync_in_i),
    .chip_select_n_i(chip_select_n_i),
    .serial_clk_i(serial_clk_i),
    .ext_sampling_mode_i(ext_sampling_mode_i),
    .conv_mode_i(conv_mode_i),
    .sample_end_i(sample_end_i),
    .conv_done_i(conv_done_i),
    .sampling_o(sampling_o),
    .conv_start_o(conv_start_o),
    .conv_busy_o(conv_busy_o),
    .status_n_o(status_n_o),
    .frame_start_o(frame_start_o),
    .cycle_active_o(cycle_active_o),
    .serial_en_o(serial_en_o),
    .sdo_oe_o(sdo_oe_o),
    .edge_count_o(edge_count_o),
    .early_trigger_o(early_trigger_o)
);

`default_nettype wire

//--- testbench/adcsfc_host_model.sv
// host side model: drives trigger, frame sync, chip select and sclk
// assumes the bench clock; sclk runs only inside bursts, 160 ns period
`timescale 1ns/10ps
`default_nettype none

module adcsfc_host_model (
    input wire logic clk_sys_i,
    output logic trig_n_o,
    output logic fs_o,
    output logic cs_n_o,
    output logic sclk_o
);
    int rises = 0;

    // idle levels: unused trigger and frame sync are parked high
    initial begin
        trig_n_o = 1'b1;
        fs_o = 1'b1;
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
    end

    task automatic set_cs(input logic v);
        @(negedge clk_sys_i);
        cs_n_o = v;
    endtask

    task automatic set_fs(input logic v);
        @(negedge clk_sys_i);
        fs_o = v;
    endtask

    // a real host may not trigger before enough sclk rises have passed
    task automatic set_trig(input logic v);
        if (!v) wait (rises >= 11);
        @(negedge clk_sys_i);
        trig_n_o = v;
    endtask

    // sclk is offset so its edges do not line up with clk_sys_i
    task automatic clocks(input int n);
        #1.7;
        repeat (n) begin
            sclk_o = 1'b1;
            rises++;
            #80;
            sclk_o = 1'b0;
            #80;
        end
    endtask
endmodule

`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for adcsfc_top with a host pin model
// assumes 250 MHz clk_sys_i; the bench plays the converter core
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; \
    if ((got) !== (ex)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); end end

module tb_top;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic ext_mode = 1'b0;
    logic [1:0] conv_mode = 2'h0;
    logic sample_end = 1'b0;
    logic conv_done = 1'b0;
    wire trig_n, fs, cs_n, sclk, sampling, conv_busy, status_n;
    wire frame_start, cycle_active, serial_en, sdo_oe;
    wire [3:0] edge_count;
    wire early_trig;
    int n_mismatch = 0;
    int total_checks = 0;
    int n_frames = 0;

    // ------------------------------------------------------------
    // clock, pulse counting and instances
    // ------------------------------------------------------------
    always #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (frame_start === 1'b1) n_frames++;

    adcsfc_host_model host (.clk_sys_i(clk_sys_i), .trig_n_o(trig_n),
        .fs_o(fs), .cs_n_o(cs_n), .sclk_o(sclk));
    adcsfc_top DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .ext_sample_trigger_n_i(trig_n), .frame_sync_in_i(fs),
        .chip_select_n_i(cs_n), .serial_clk_i(sclk),
        .ext_sampling_mode_i(ext_mode), .conv_mode_i(conv_mode),
        .sample_end_i(sample_end), .conv_done_i(conv_done),
        .sampling_o(sampling), .conv_start_o(), .conv_busy_o(conv_busy),
        .status_n_o(status_n), .frame_start_o(frame_start),
        .cycle_active_o(cycle_active), .serial_en_o(serial_en),
        .sdo_oe_o(sdo_oe), .edge_count_o(edge_count),
        .early_trigger_o(early_trig));

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    // one-cycle core pulse: done when the argument is set, else sample end;
    // driven directly so the pulse is seen while it stands
    task automatic pulse(input bit done);
        @(negedge clk_sys_i);
        if (done) conv_done = 1'b1;
        else sample_end = 1'b1;
        @(negedge clk_sys_i);
        conv_done = 1'b0;
        sample_end = 1'b0;
        cyc(2);
    endtask

    task automatic t_spi_frame;
        int f0;
        f0 = n_frames;
        host.set_cs(1'b0);
        cyc(8);
        `CHK("cs start", f0 + 1, n_frames)
        `CHK("count clear", 4'h0, edge_count)
        host.clocks(5);
        cyc(8);
        `CHK("count five", 4'h5, edge_count)
        host.clocks(11);
        cyc(8);
        `CHK("frame end", 2'h0, {serial_en, cycle_active})
        host.set_cs(1'b1);
        cyc(8);
    endtask

    task automatic t_fs_frame;
        int f0;
        f0 = n_frames;
        host.set_fs(1'b0);
        cyc(6);
        host.set_cs(1'b0);
        cyc(10);
        `CHK("armed waits", f0, n_frames)
        host.clocks(3);
        host.set_fs(1'b1);
        cyc(8);
        `CHK("fs start", f0 + 1, n_frames)
        `CHK("fs count clear", 4'h0, edge_count)
        host.clocks(2);
        host.set_fs(1'b0);
        cyc(4);
        host.set_fs(1'b1);
        cyc(8);
        `CHK("fs restart", f0 + 2, n_frames)
        `CHK("restart clear", 4'h0, edge_count)
        host.set_cs(1'b1);
        cyc(8);
    endtask

    // chip select traffic inside the window must not disturb sampling
    task automatic t_ext_eoc;
        ext_mode = 1'b1;
        host.set_trig(1'b0);
        cyc(8);
        `CHK("window open", 1'b1, sampling)
        host.set_cs(1'b0);
        host.clocks(2);
        host.set_cs(1'b1);
        cyc(30);
        `CHK("window held", 1'b1, sampling)
        `CHK("flag idle", 1'b1, status_n)
        host.set_trig(1'b1);
        cyc(8);
        `CHK("window shut", 1'b0, sampling)
        `CHK("busy", 1'b1, conv_busy)
        cyc(20);
        `CHK("flag low", 1'b0, status_n)
        pulse(1'b1);
        `CHK("flag high", 1'b1, status_n)
        `CHK("busy done", 1'b0, conv_busy)
        ext_mode = 1'b0;
        pulse(1'b0);
        `CHK("internal end", 1'b0, status_n)
        pulse(1'b1);
    endtask

    // one clear source per interrupt mode covers all three modes
    task automatic t_int_modes;
        for (int m = 1; m < 4; m++) begin
            conv_mode = m[1:0];
            pulse(1'b1);
            cyc(10);
            `CHK("int held", 1'b0, status_n)
            if (m == 1) host.set_cs(1'b0);
            else if (m == 2) begin
                // a low shorter than the filter would be swallowed
                host.set_fs(1'b0);
                cyc(4);
            end
            host.set_fs(1'b1);
            if (m == 3) host.set_trig(1'b0);
            cyc(8);
            `CHK("int clear", 1'b1, status_n)
            `CHK("no window", 1'b0, sampling)
            host.set_cs(1'b1);
            host.set_trig(1'b1);
            cyc(8);
        end
    endtask

    // mid-run reset: the sclk rise count restarts, so the next trigger
    // fall is a first fall before the 11th rise and must be flagged
    task automatic t_reset_early;
        `CHK("no early", 1'b0, early_trig)
        @(negedge clk_sys_i);
        rst_i = 1'b1;
        cyc(2);
        rst_i = 1'b0;
        cyc(1);
        `CHK("reset idle", 3'h4, {status_n, sampling, serial_en})
        host.set_trig(1'b0);
        cyc(8);
        `CHK("early flag", 1'b1, early_trig)
        `CHK("mode off", 1'b0, sampling)
        host.set_trig(1'b1);
        cyc(8);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        cyc(4);
        rst_i = 1'b0;
        cyc(2);
        t_spi_frame;
        t_fs_frame;
        t_ext_eoc;
        t_int_modes;
        t_reset_early;
        give_verdict;
    end

    // a hang is cut off well after the expected ~5 us of traffic
    initial begin
        #200000;
        n_mismatch++;
        give_verdict;
    end
endmodule

`default_nettype wire
